/* File: verilog/fuse_pkg.sv */
// Constants for the fuse PROM programming sequencer.
// Assumes a 125 MHz system clock; the PROM itself has no clock.
package fuse_pkg;
  localparam int CLK_MHZ = 125;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int WORDS = 512;
  // Times in their own units
  localparam int FIRST_PULSE_US = 50;
  localparam int FIRST_PULSE_MAX_US = 100;
  localparam int LATER_PULSE_MS = 5;
  localparam int LATER_PULSE_MAX_MS = 15;
  localparam int TOTAL_PULSE_MS = 400;
  localparam int EDGE_DELAY_NS = 200;
  localparam int EDGE_DELAY_MIN_NS = 100;
  localparam int EDGE_DELAY_MAX_NS = 1000;
  localparam int HEAT_LIMIT_MS = 5000;
  localparam int COOL_MS = 5000;
  localparam int VERIFY_NS = 400;
  localparam int LEADER_RUBOUTS = 25;
  // Cycle counts
  localparam int FIRST_PULSE_CYC = FIRST_PULSE_US * CLK_MHZ;
  localparam int LATER_PULSE_CYC = LATER_PULSE_MS * 1000 * CLK_MHZ;
  localparam int EDGE_DELAY_CYC = (EDGE_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int VERIFY_CYC = (VERIFY_NS * CLK_MHZ + 999) / 1000;
  localparam int LATER_PULSES_MAX =
    (TOTAL_PULSE_MS - 1) / LATER_PULSE_MS;
  localparam longint HEAT_LIMIT_CYC =
    longint'(HEAT_LIMIT_MS) * 1000 * CLK_MHZ;
  localparam longint COOL_CYC = longint'(COOL_MS) * 1000 * CLK_MHZ;
  // Tape characters
  localparam logic [6:0] CH_BEGIN = 7'h42;
  localparam logic [6:0] CH_FINISH = 7'h46;
  localparam logic [6:0] CH_HIGH = 7'h50;
  localparam logic [6:0] CH_LOW = 7'h4E;
  localparam logic [6:0] CH_RUBOUT = 7'h7F;
  typedef enum logic [1:0] {
    TP_SKIP, TP_DATA, TP_WAIT_F
  } tape_st_t;
  typedef enum logic [3:0] {
    SQ_IDLE, SQ_LOAD, SQ_FIND, SQ_CS_UP, SQ_VOP_ON, SQ_CS_HV,
    SQ_PULSE, SQ_CS_DN, SQ_VOP_OFF, SQ_SENSE, SQ_COOL, SQ_VERIFY,
    SQ_DONE, SQ_FAIL
  } seq_st_t;
endpackage

/* File: verilog/fuse_image_mem.sv */
// Image memory holding the parsed tape pattern.
// One write port, one read port with registered read data.
`timescale 1ns/1ps
module fuse_image_mem
  import fuse_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)(
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge clk_i)
  begin
    if (ce_i && we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    if (ce_i)
    begin
      rdata_o <= mem_q[raddr_i];
    end
  end
endmodule

/* File: verilog/fuse_prog_seq.sv */
// Host-side sequencer that parses a framed word tape and burns a
// 512x8 fusible PROM one bit at a time, then verifies every word.
// Assumes external level shifters turn the drive strobes into the
// 15 V select, 20 V output supply and output load switching.
`timescale 1ns/1ps
module fuse_prog_seq
  import fuse_pkg::*;
#(
  parameter longint HEAT_CYC = HEAT_LIMIT_CYC,
  parameter longint COOL_CYC_P = COOL_CYC,
  parameter int LATER_CYC = LATER_PULSE_CYC,
  parameter int FIRST_CYC = FIRST_PULSE_CYC,
  parameter int NWORDS = WORDS
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Tape character stream
  input wire logic [7:0] tape_char_i,
  input wire logic tape_valid_i,
  input wire logic parity_chk_i,
  input wire logic tape_end_i,
  // Control
  input wire logic start_i,
  // PROM pins
  output logic [ADDR_W-1:0] prom_addr_o,
  output logic cs_high_o,
  output logic cs_hv_o,
  output logic [DATA_W-1:0] vop_en_o,
  output logic [DATA_W-1:0] load_en_o,
  output logic vcc_on_o,
  input wire logic [DATA_W-1:0] prom_data_i,
  // Status
  output logic tape_ok_o,
  output logic tape_err_o,
  output logic busy_o,
  output logic done_o,
  output logic burn_fail_o,
  output logic verify_fail_o,
  output logic [ADDR_W-1:0] fail_addr_o
);
  // Pulse timer is 23 bits wide; image holds at most WORDS words
  if (NWORDS < 1 || NWORDS > WORDS || FIRST_CYC < 1 || LATER_CYC < 1
    || FIRST_CYC >= 2**23 || LATER_CYC >= 2**23 || HEAT_CYC < 1
    || COOL_CYC_P < 1)
  begin : g_bad_params
    $error("fuse_prog_seq: unsupported parameter values");
  end

  function automatic logic even_par(input logic [7:0] c);
    return ~^c;
  endfunction

  // Tape parser
  tape_st_t tp_q, tp_d;
  logic [3:0] nbits_q, nbits_d;
  logic [7:0] shf_q, shf_d;
  logic [ADDR_W:0] wcnt_q, wcnt_d;
  logic [5:0] rub_q, rub_d;
  logic lead_ok_q, lead_ok_d;
  logic terr_q, terr_d;
  logic tok_q, tok_d;
  wire logic [6:0] ch = tape_char_i[6:0];
  wire logic tv = tape_valid_i && ce_i;
  wire logic par_bad = parity_chk_i && !even_par(tape_char_i);
  wire logic is_rub = (ch == CH_RUBOUT);
  wire logic is_dat = (ch == CH_HIGH) || (ch == CH_LOW);
  wire logic wr_word = tv && tp_q == TP_WAIT_F && ch == CH_FINISH
    && !par_bad && !terr_q;
  wire logic trail_ok = rub_q >= 6'(LEADER_RUBOUTS);

  always_comb
  begin
    tp_d = tp_q;
    nbits_d = nbits_q;
    shf_d = shf_q;
    wcnt_d = wcnt_q;
    rub_d = rub_q;
    lead_ok_d = lead_ok_q;
    terr_d = terr_q;
    tok_d = tok_q;
    if (tv)
    begin
      rub_d = is_rub ? ((rub_q == 6'h3F) ? rub_q : rub_q + 6'h01) : 6'h00;
      if (!lead_ok_q)
      begin
        if (!is_rub && !trail_ok)
          terr_d = 1'b1;
        if (!is_rub)
          lead_ok_d = 1'b1;
      end
      if (par_bad)
        terr_d = 1'b1;
      case (tp_q)
        TP_SKIP:
        begin
          if (ch == CH_BEGIN)
          begin
            tp_d = TP_DATA;
            nbits_d = 4'h0;
          end
        end
        TP_DATA, TP_WAIT_F:
        begin
          if (is_rub)
          begin
            if (nbits_q == 4'h0)
              tp_d = TP_SKIP;
            else
            begin
              nbits_d = nbits_q - 4'h1;
              // Drop the rubbed-out letter
              shf_d = shf_q >> 1;
              tp_d = TP_DATA;
            end
          end
          else if (tp_q == TP_DATA && is_dat)
          begin
            shf_d = {shf_q[6:0], ch == CH_HIGH};
            nbits_d = nbits_q + 4'h1;
            if (nbits_q == 4'h7)
              tp_d = TP_WAIT_F;
          end
          else if (tp_q == TP_WAIT_F && ch == CH_FINISH)
          begin
            tp_d = TP_SKIP;
            wcnt_d = wcnt_q + 10'h001;
          end
          else
          begin
            terr_d = 1'b1;
            tp_d = TP_SKIP;
          end
        end
        default: tp_d = TP_SKIP;
      endcase
    end
    if (tape_end_i && ce_i)
    begin
      if (wcnt_q != 10'(NWORDS) || tp_q != TP_SKIP || !trail_ok)
        terr_d = 1'b1;
      else if (!terr_q)
        tok_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tp_q <= TP_SKIP;
      nbits_q <= 4'h0;
      shf_q <= 8'h00;
      wcnt_q <= '0;
      rub_q <= 6'h00;
      lead_ok_q <= 1'b0;
      terr_q <= 1'b0;
      tok_q <= 1'b0;
    end
    else if (ce_i)
    begin
      tp_q <= tp_d;
      nbits_q <= nbits_d;
      shf_q <= shf_d;
      wcnt_q <= wcnt_d;
      rub_q <= rub_d;
      lead_ok_q <= lead_ok_d;
      terr_q <= terr_d;
      tok_q <= tok_d;
    end
  end

  // Sequencer
  seq_st_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] bit_q, bit_d;
  logic [22:0] tmr_q, tmr_d;
  logic [39:0] heat_q, heat_d;
  logic [7:0] npulse_q, npulse_d;
  logic first_q, first_d;
  logic burnt_q, burnt_d;
  logic [DATA_W-1:0] img_q;
  logic bfail_q, bfail_d, vfail_q, vfail_d, done_q, done_d;
  logic [ADDR_W-1:0] faddr_q, faddr_d;
  logic [ADDR_W-1:0] raddr;

  fuse_image_mem u_mem (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(wr_word),
    .waddr_i(wcnt_q[ADDR_W-1:0]),
    .wdata_i(shf_q),
    .raddr_i(raddr),
    .rdata_o(img_q)
  );
  assign raddr = addr_d;

  wire logic tmr_end = (tmr_q == 23'h0);
  wire logic want_hi = img_q[bit_q];
  wire logic bit_last = (bit_q == 3'h7);
  wire logic addr_last = (addr_q == ADDR_W'(NWORDS - 1));
  wire logic heat_hit = heat_q >= 40'(HEAT_CYC);
  wire logic pulse_st = (st_q == SQ_PULSE);
  wire logic prog_active = st_q inside {SQ_CS_UP, SQ_VOP_ON, SQ_CS_HV,
    SQ_PULSE, SQ_CS_DN, SQ_VOP_OFF};
  wire logic [DATA_W-1:0] bit_mask = DATA_W'(1) << bit_q;

  function automatic logic [22:0] cyc(input int n);
    return 23'(n);
  endfunction

  always_comb
  begin
    st_d = st_q;
    addr_d = addr_q;
    bit_d = bit_q;
    tmr_d = tmr_end ? tmr_q : tmr_q - 23'h1;
    heat_d = prog_active ? heat_q + 40'h1 : heat_q;
    npulse_d = npulse_q;
    first_d = first_q;
    burnt_d = burnt_q;
    bfail_d = bfail_q;
    vfail_d = vfail_q;
    faddr_d = faddr_q;
    done_d = done_q;
    case (st_q)
      SQ_IDLE:
        if (start_i && tok_q)
        begin
          st_d = SQ_LOAD;
          addr_d = '0;
          bit_d = 3'h0;
          burnt_d = 1'b0;
          heat_d = '0;
          bfail_d = 1'b0;
          vfail_d = 1'b0;
          done_d = 1'b0;
        end
      SQ_LOAD: st_d = SQ_FIND;
      SQ_FIND:
        if (heat_hit)
        begin
          st_d = SQ_COOL;
          heat_d = '0;
          first_d = 1'b1;
        end
        else if (want_hi && !burnt_q)
        begin
          st_d = SQ_CS_UP;
          first_d = 1'b1;
          npulse_d = 8'h00;
          tmr_d = cyc(EDGE_DELAY_CYC);
        end
        else if (bit_last)
        begin
          bit_d = 3'h0;
          burnt_d = 1'b0;
          addr_d = addr_q + ADDR_W'(1);
          st_d = addr_last ? SQ_VERIFY : SQ_LOAD;
          if (addr_last)
          begin
            addr_d = '0;
            tmr_d = cyc(VERIFY_CYC);
          end
        end
        else
        begin
          bit_d = bit_q + 3'h1;
          burnt_d = 1'b0;
        end
      SQ_CS_UP:
        if (tmr_end)
        begin
          st_d = SQ_VOP_ON;
          tmr_d = cyc(EDGE_DELAY_CYC);
        end
      SQ_VOP_ON:
        if (tmr_end)
        begin
          st_d = SQ_CS_HV;
          tmr_d = cyc(first_q ? FIRST_CYC : LATER_CYC);
        end
      SQ_CS_HV: st_d = SQ_PULSE;
      SQ_PULSE:
        if (tmr_end)
        begin
          st_d = SQ_CS_DN;
          tmr_d = cyc(EDGE_DELAY_CYC);
        end
      SQ_CS_DN:
        if (tmr_end)
        begin
          st_d = SQ_VOP_OFF;
          // Deselect holds one edge delay after supply drops
          tmr_d = cyc(EDGE_DELAY_CYC + VERIFY_CYC);
        end
      SQ_VOP_OFF:
        if (tmr_end)
          st_d = SQ_SENSE;
      SQ_SENSE:
        if (prom_data_i[bit_q])
        begin
          st_d = SQ_FIND;
          burnt_d = 1'b1;
        end
        else if (npulse_q >= 8'(LATER_PULSES_MAX))
        begin
          st_d = SQ_FAIL;
          bfail_d = 1'b1;
          faddr_d = addr_q;
        end
        else
        begin
          // Retries cool down too, keeping the pulse count
          st_d = heat_hit ? SQ_COOL : SQ_CS_UP;
          if (heat_hit)
            heat_d = '0;
          npulse_d = npulse_q + 8'h01;
          first_d = 1'b0;
          tmr_d = cyc(EDGE_DELAY_CYC);
        end
      SQ_COOL:
        if (heat_q >= 40'(COOL_CYC_P))
        begin
          st_d = first_q ? SQ_LOAD : SQ_CS_UP;
          heat_d = '0;
          tmr_d = cyc(EDGE_DELAY_CYC);
        end
        else
          heat_d = heat_q + 40'h1;
      SQ_VERIFY:
        if (tmr_end)
        begin
          if (prom_data_i != img_q)
          begin
            vfail_d = 1'b1;
            faddr_d = addr_q;
            st_d = SQ_FAIL;
          end
          else if (addr_last)
          begin
            st_d = SQ_DONE;
            done_d = 1'b1;
          end
          else
          begin
            addr_d = addr_q + ADDR_W'(1);
            tmr_d = cyc(VERIFY_CYC);
          end
        end
      SQ_DONE, SQ_FAIL:
        if (start_i)
          st_d = SQ_IDLE;
      default: st_d = SQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= SQ_IDLE;
      addr_q <= '0;
      bit_q <= 3'h0;
      tmr_q <= '0;
      heat_q <= '0;
      npulse_q <= 8'h00;
      first_q <= 1'b0;
      burnt_q <= 1'b0;
      bfail_q <= 1'b0;
      vfail_q <= 1'b0;
      faddr_q <= '0;
      done_q <= 1'b0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      bit_q <= bit_d;
      tmr_q <= tmr_d;
      heat_q <= heat_d;
      npulse_q <= npulse_d;
      first_q <= first_d;
      burnt_q <= burnt_d;
      bfail_q <= bfail_d;
      vfail_q <= vfail_d;
      faddr_q <= faddr_d;
      done_q <= done_d;
    end
  end

  // Supply already off, select not yet enabled
  wire logic vop_settle = (st_d == SQ_VOP_OFF) && (tmr_d > cyc(VERIFY_CYC));

  // Registered pin drive
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prom_addr_o <= '0;
      cs_high_o <= 1'b1;
      cs_hv_o <= 1'b0;
      vop_en_o <= '0;
      load_en_o <= '0;
      vcc_on_o <= 1'b0;
      tape_ok_o <= 1'b0;
      tape_err_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      burn_fail_o <= 1'b0;
      verify_fail_o <= 1'b0;
      fail_addr_o <= '0;
    end
    else if (ce_i)
    begin
      prom_addr_o <= addr_d;
      cs_high_o <= st_d inside {SQ_CS_UP, SQ_VOP_ON, SQ_CS_HV, SQ_PULSE,
        SQ_CS_DN, SQ_IDLE, SQ_DONE, SQ_FAIL, SQ_COOL}
        || vop_settle;
      cs_hv_o <= st_d inside {SQ_CS_HV, SQ_PULSE};
      vop_en_o <= (st_d inside {SQ_VOP_ON, SQ_CS_HV, SQ_PULSE, SQ_CS_DN})
        ? (DATA_W'(1) << bit_d) : '0;
      load_en_o <= (st_d inside {SQ_VOP_OFF, SQ_SENSE})
        ? (DATA_W'(1) << bit_d) : '0;
      vcc_on_o <= !(st_d inside {SQ_IDLE, SQ_COOL, SQ_DONE, SQ_FAIL});
      tape_ok_o <= tok_d;
      tape_err_o <= terr_d;
      busy_o <= !(st_d inside {SQ_IDLE, SQ_DONE, SQ_FAIL});
      done_o <= done_d;
      burn_fail_o <= bfail_d;
      verify_fail_o <= vfail_d;
      fail_addr_o <= faddr_d;
    end
  end

  // Assertions
  a_hv_needs_cs: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cs_hv_o |-> cs_high_o) else $error("select raised low");
  a_vop_after_cs: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(|vop_en_o) |-> $past(cs_high_o)) else
    $error("supply before select");
  a_one_fuse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $onehot0(vop_en_o)) else $error("more than one fuse");
  a_edge_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(|vop_en_o) |-> $past(cs_high_o, 2)) else
    $error("edge gap too short");
  a_enable_gap: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(cs_high_o) |-> !(|$past(vop_en_o, 2))) else
    $error("enable too soon after supply");
  a_fail_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && burn_fail_o && st_q == SQ_FAIL && !start_i |=> burn_fail_o)
    else $error("fail flag lost");
  a_load_off_vop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    |load_en_o |-> !(|vop_en_o)) else $error("load with supply");
  a_pulse_len: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i && $rose(pulse_st) && first_q |-> tmr_q <= 23'(FIRST_CYC)) else
    $error("first pulse too long");
  a_word_store: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    wr_word |-> nbits_q == 4'h8) else $error("short word stored");
  c_burn: cover property (@(posedge clk_i) $rose(cs_hv_o));
  c_retry: cover property (@(posedge clk_i) st_q == SQ_SENSE && !first_q);
  c_done: cover property (@(posedge clk_i) $rose(done_o));
  c_terr: cover property (@(posedge clk_i) $rose(tape_err_o));
endmodule

/* File: tb/prom_model.sv */
// Behavioural 512x8 fuse PROM answering the sequencer's pins.
// Mode 1 links need one later pulse, mode 2 links never open.
`timescale 1ns/1ps
module prom_model
  import fuse_pkg::*;
#(
  parameter int FIRST = 50,
  parameter int LATER = 100,
  parameter int HEAT = 2000,
  parameter int COOL = 100
)(
  // Pins
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic cs_high_i,
  input wire logic cs_hv_i,
  input wire logic [DATA_W-1:0] vop_en_i,
  input wire logic vcc_on_i,
  output logic [DATA_W-1:0] data_o,
  // Test controls and findings
  input wire logic [1:0] mode_i,
  input wire logic glitch_i,
  output int errs_o,
  output int pulses_o,
  output int cools_o
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] junk = 8'hA5;
  logic [11:0] last;
  int plen, burn, heat, off;
  wire sel = vcc_on_i && !cs_high_i && !cs_hv_i;
  // Deselected outputs float, shown as a changing pattern
  assign data_o = sel ? mem[addr_i] : junk;
  always @(posedge clk_i or negedge rst_b_i)
  begin
    int b;
    int nb;
    logic [11:0] k;
    b = 0;
    for (int i = 0; i < DATA_W; i++)
      if (vop_en_i[i])
        b = i;
    k = {addr_i, 3'(b)};
    nb = (plen == 0 && k != last) ? 1 : burn + 1;
    if (!rst_b_i)
    begin
      foreach (mem[i])
        mem[i] <= '0;
      {errs_o, pulses_o, cools_o, plen, burn, heat} <= '0;
      off <= COOL;
      last <= '1;
    end
    else
    begin
      junk <= ~junk;
      off <= vcc_on_i ? 0 : off + 1;
      heat <= vcc_on_i ? heat + 1 : (off >= COOL - 1 ? 0 : heat);
      if (vcc_on_i && off != 0)
        cools_o <= cools_o + 1;
      if (vcc_on_i && off != 0 && off < COOL - 1)
        errs_o <= errs_o + 1;
      if (vop_en_i != 0 && (heat > 2 * HEAT || $countones(vop_en_i) > 1
          || !(cs_high_i || cs_hv_i)))
        errs_o <= errs_o + 1;
      if (cs_hv_i)
      begin
        plen <= plen + 1;
        burn <= nb;
        if (plen == 0)
          pulses_o <= (k == last) ? pulses_o + 1 : 1;
        last <= k;
        if (mode_i != 2 && nb >= (mode_i == 1 ? FIRST + LATER : FIRST))
        begin
          mem[addr_i][b] <= 1'b1;
          if (glitch_i && addr_i >= 3)
            mem[addr_i][(b + 1) % 8] <= 1'b1;
        end
      end
      else if (plen != 0)
      begin
        plen <= 0;
        if (pulses_o == 1 ? (plen < FIRST || plen > 2 * FIRST)
            : (plen < LATER || plen > 3 * LATER))
          errs_o <= errs_o + 1;
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the fuse PROM programming sequencer.
// Feeds framed tapes, starts burns, a PROM model answers the pins.
`timescale 1ns/1ps
module tb_top
  import fuse_pkg::*;
;
  localparam int NW = 8;
  logic clk_i = 0, rst_b_i = 0, ce_i = 1, tape_valid_i = 0;
  logic parity_chk_i = 0, tape_end_i = 0, start_i = 0, glitch = 0;
  logic [7:0] tape_char_i = '0;
  logic [1:0] mode = 0;
  logic [ADDR_W-1:0] prom_addr_o, fail_addr_o;
  logic cs_high_o, cs_hv_o, vcc_on_o, tape_ok_o, tape_err_o, busy_o;
  logic done_o, burn_fail_o, verify_fail_o;
  logic [DATA_W-1:0] vop_en_o, load_en_o, prom_data_i;
  logic [7:0] img [NW];
  logic [31:0] seed = 53;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  int errs, pulses, cools;

  initial
    forever #4 clk_i = ~clk_i;

  fuse_prog_seq #(.HEAT_CYC(2000), .COOL_CYC_P(100), .LATER_CYC(100),
    .FIRST_CYC(50), .NWORDS(NW)) i_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .tape_char_i(tape_char_i), .tape_valid_i(tape_valid_i),
    .parity_chk_i(parity_chk_i), .tape_end_i(tape_end_i),
    .start_i(start_i), .prom_addr_o(prom_addr_o), .cs_high_o(cs_high_o),
    .cs_hv_o(cs_hv_o), .vop_en_o(vop_en_o), .load_en_o(load_en_o),
    .vcc_on_o(vcc_on_o), .prom_data_i(prom_data_i), .tape_ok_o(tape_ok_o),
    .tape_err_o(tape_err_o), .busy_o(busy_o), .done_o(done_o),
    .burn_fail_o(burn_fail_o), .verify_fail_o(verify_fail_o),
    .fail_addr_o(fail_addr_o));

  prom_model i_prom (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(prom_addr_o),
    .cs_high_i(cs_high_o), .cs_hv_i(cs_hv_o), .vop_en_i(vop_en_o),
    .vcc_on_i(vcc_on_o), .data_o(prom_data_i), .mode_i(mode),
    .glitch_i(glitch), .errs_o(errs), .pulses_o(pulses), .cools_o(cools));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction

  // First word from 3 up where a stray neighbour link shows
  function automatic int first_bad();
    for (int a = 3; a < NW; a++)
      if ((img[a] | {img[a][6:0], img[a][7]}) != img[a])
        return a;
    return 0;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic put(logic [6:0] c, logic bad = 0);
    @(negedge clk_i);
    tape_char_i = {^c ^ bad, c};
    tape_valid_i = 1;
    @(negedge clk_i);
    tape_valid_i = 0;
  endtask

  // Kind 0 good, 1 stray letter, 2 nine letters, 3 short,
  // 4 parity slip, 5 short trailer
  task automatic send_tape(int kind);
    for (int w = 0; w < NW - (kind == 3); w++)
    begin
      if (w == 0)
        repeat (25) put(CH_RUBOUT);
      put(7'h0D);
      put(7'h30);
      if (w == 1)
      begin
        put(CH_BEGIN);
        repeat (3) put(CH_HIGH);
        repeat (4) put(CH_RUBOUT);
      end
      put(CH_BEGIN);
      for (int i = 7; i >= 0; i--)
        put(img[w][i] ? CH_HIGH : CH_LOW, kind == 4 && w == 2);
      if (w == 2 && kind == 1)
        put(7'h58);
      if (w == 2 && kind == 2)
        put(CH_LOW);
      put(CH_FINISH);
      put(7'h43);
      put(7'h0A);
    end
    repeat (kind == 5 ? 10 : 25) put(CH_RUBOUT);
    @(negedge clk_i);
    tape_end_i = 1;
    @(negedge clk_i);
    tape_end_i = 0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic reset_dut();
    @(negedge clk_i);
    rst_b_i = 0;
    repeat (2) @(negedge clk_i);
    check(cs_high_o, 1, "reset select");
    check({vcc_on_o, cs_hv_o, busy_o, vop_en_o, load_en_o}, 0,
      "reset outputs");
    rst_b_i = 1;
  endtask

  initial
  begin
    for (int t = 0; t < 9; t++)
    begin
      int kind;
      kind = t < 4 ? 0 : t - 3;
      mode = t == 1 ? 2'd1 : t == 2 ? 2'd2 : 2'd0;
      glitch = t == 3;
      foreach (img[w])
      begin
        seed = xs(seed);
        img[w] = seed[7:0] | 8'h11;
      end
      img[NW-1] = 8'h11;
      parity_chk_i = kind == 4 || seed[9];
      reset_dut();
      send_tape(kind);
      check(tape_ok_o, kind == 0, "tape ok");
      check(tape_err_o, kind != 0, "tape error");
      start_i = 1;
      @(negedge clk_i);
      start_i = 0;
      @(negedge clk_i);
      check(busy_o, kind == 0, "busy");
      if (kind == 0)
      begin
        // Random clock-enable stalls during two of the burns
        while (done_o !== 1 && burn_fail_o !== 1 && verify_fail_o !== 1)
        begin
          @(negedge clk_i);
          seed = xs(seed);
          ce_i = (t != 0 && t != 3) || seed[3:0] != 4'h0;
        end
        ce_i = 1;
        @(negedge clk_i);
        check(burn_fail_o, t == 2, "burn fail");
        check(verify_fail_o, t == 3, "verify fail");
        check(done_o, t < 2, "done");
        check(errs, 0, "pin sequence");
        if (t == 2)
        begin
          check(pulses, 1 + LATER_PULSES_MAX, "pulses");
          check(fail_addr_o, 0, "burn fail address");
        end
        if (t == 3)
          check(fail_addr_o, first_bad(), "fail address");
        if (t < 2)
        begin
          check(cools > 1, 1, "cooling");
          foreach (img[w])
            check(i_prom.mem[w], img[w], "word");
        end
      end
      $display("test %0d finished", t);
    end
    wrap_up();
  end
endmodule
